// ===== core/ssmd_top.sv
`timescale 1ns/1ps
module ssmd_top #(
  parameter int SETTLE_CYC = ssmd_pkg::SSMD_SETTLE_CYC
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  // axi4-lite write
  input wire logic [7:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  // axi4-lite read
  input wire logic [7:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  // decoded unit states and wake-up
  output ssmd_pkg::ssmd_unit_e low_sv_state_o,
  output ssmd_pkg::ssmd_unit_e low_mon_state_o,
  output ssmd_pkg::ssmd_unit_e high_sv_state_o,
  output ssmd_pkg::ssmd_unit_e high_mon_state_o,
  output logic wake_slow_o,
  output logic affected_config_o,
  output logic low_side_settling_flag_o,
  output logic high_side_settling_flag_o,
  output logic irq_o
);
  import ssmd_pkg::*;

  // decode of one unit for a mode; keep bit forced for monitors
  function automatic ssmd_unit_e unit_dec(input logic en, input logic keep, input logic fp,
                                          input logic auto_c, input ssmd_mode_e m);
    ssmd_unit_e r;
    r = SSMD_OFF;
    if (!en) begin
      r = SSMD_OFF;
    end else if (m != SSMD_DEEP) begin
      r = fp ? SSMD_FULL : SSMD_NORMAL;
    end else if (!keep) begin
      r = SSMD_OFF;
    end else if (!auto_c) begin
      r = fp ? SSMD_FULL : SSMD_NORMAL;
    end else begin
      r = fp ? SSMD_NORMAL : SSMD_OFF;
    end
    return r;
  endfunction : unit_dec

  logic [5:0] low_ctl, next_low_ctl, high_ctl, next_high_ctl;
  ssmd_mode_e mode, next_mode;
  logic [5:0] low_snap, next_low_snap, high_snap, next_high_snap;
  logic [17:0] low_cnt, next_low_cnt, high_cnt, next_high_cnt;
  logic [2:0] irq_stat, next_irq_stat, irq_en, next_irq_en;
  logic aw_got, next_aw_got, w_got, next_w_got, bvalid, next_bvalid;
  logic [7:0] aw_addr, next_aw_addr;
  logic [31:0] w_data, next_w_data;
  logic [1:0] bresp, next_bresp, rresp, next_rresp;
  logic rvalid, next_rvalid;
  logic [31:0] rdata, next_rdata;
  ssmd_unit_e next_lsv, next_lmon, next_hsv, next_hmon;
  logic next_wake_slow, next_affected;
  logic wr_fire, mode_chg, low_wr, high_wr, deep_entry_early;
  logic [2:0] ev;

  assign s_axi_awready_o = !aw_got && !bvalid;
  assign s_axi_wready_o = !w_got && !bvalid;
  assign s_axi_arready_o = !rvalid;
  assign s_axi_bvalid_o = bvalid;
  assign s_axi_bresp_o = bresp;
  assign s_axi_rvalid_o = rvalid;
  assign s_axi_rdata_o = rdata;
  assign s_axi_rresp_o = rresp;
  assign low_side_settling_flag_o = (low_cnt != 18'h0);
  assign high_side_settling_flag_o = (high_cnt != 18'h0);
  assign irq_o = |(irq_stat & irq_en);

  always_comb begin
    next_aw_got = aw_got;
    next_aw_addr = aw_addr;
    next_w_got = w_got;
    next_w_data = w_data;
    next_bvalid = bvalid;
    next_bresp = bresp;
    next_low_ctl = low_ctl;
    next_high_ctl = high_ctl;
    next_mode = mode;
    next_irq_en = irq_en;
    low_wr = 1'b0;
    high_wr = 1'b0;
    if (s_axi_awvalid_i && s_axi_awready_o) begin
      next_aw_got = 1'b1;
      next_aw_addr = s_axi_awaddr_i;
    end
    if (s_axi_wvalid_i && s_axi_wready_o) begin
      next_w_got = 1'b1;
      next_w_data = s_axi_wdata_i;
    end
    wr_fire = aw_got && w_got && !bvalid;
    if (wr_fire) begin
      next_aw_got = 1'b0;
      next_w_got = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = SSMD_RESP_OKAY;
      unique case (aw_addr)
        SSMD_ADDR_LOW_CTL: begin
          next_low_ctl = w_data[5:0];
          low_wr = 1'b1;
        end
        SSMD_ADDR_HIGH_CTL: begin
          next_high_ctl = w_data[5:0];
          high_wr = 1'b1;
        end
        SSMD_ADDR_MODE: begin
          if (w_data[2:0] == SSMD_ACTIVE || w_data[2:0] == SSMD_LIGHT ||
              w_data[2:0] == SSMD_DEEP) begin
            next_mode = ssmd_mode_e'(w_data[2:0]);
          end else begin
            next_bresp = SSMD_RESP_SLVERR;
          end
        end
        SSMD_ADDR_IRQ_EN: next_irq_en = w_data[2:0];
        SSMD_ADDR_IRQ_CLR, SSMD_ADDR_STATE, SSMD_ADDR_IRQ_STAT: ;
        default: next_bresp = SSMD_RESP_SLVERR;
      endcase
    end
    if (bvalid && s_axi_bready_i) begin
      next_bvalid = 1'b0;
    end
  end

  // settling counters restart on any write to that side
  always_comb begin
    next_low_cnt = low_cnt;
    next_high_cnt = high_cnt;
    if (low_wr) begin
      next_low_cnt = 18'(SETTLE_CYC);
    end else if (low_cnt != 18'h0) begin
      next_low_cnt = low_cnt - 18'h1;
    end
    if (high_wr) begin
      next_high_cnt = 18'(SETTLE_CYC);
    end else if (high_cnt != 18'h0) begin
      next_high_cnt = high_cnt - 18'h1;
    end
  end

  // snapshot settings at each mode change; deep sleep uses the snapshot
  assign mode_chg = (next_mode != mode);
  assign deep_entry_early = mode_chg && (next_mode == SSMD_DEEP) &&
                            (low_side_settling_flag_o || high_side_settling_flag_o);
  always_comb begin
    next_low_snap = mode_chg ? low_ctl : low_snap;
    next_high_snap = mode_chg ? high_ctl : high_snap;
  end

  always_comb begin
    logic [5:0] l;
    logic [5:0] h;
    logic low_fast;
    l = (next_mode == SSMD_DEEP) ? next_low_snap : next_low_ctl;
    h = (next_mode == SSMD_DEEP) ? next_high_snap : next_high_ctl;
    // hazard check calls the low side fast unless both low units run at normal
    low_fast = !(l[SSMD_B_SV_EN] && !l[SSMD_B_SV_FP]) ||
               !(l[SSMD_B_MON_EN] && !l[SSMD_B_MON_FP]);
    next_lsv = unit_dec(l[SSMD_B_SV_EN], l[SSMD_B_SV_KEEP], l[SSMD_B_SV_FP],
                        l[SSMD_B_AUTO], next_mode);
    next_lmon = unit_dec(l[SSMD_B_MON_EN], 1'b1, l[SSMD_B_MON_FP], l[SSMD_B_AUTO], next_mode);
    next_hsv = unit_dec(h[SSMD_B_SV_EN], h[SSMD_B_SV_KEEP], h[SSMD_B_SV_FP],
                        h[SSMD_B_AUTO], next_mode);
    next_hmon = unit_dec(h[SSMD_B_MON_EN], 1'b1, h[SSMD_B_MON_FP], h[SSMD_B_AUTO], next_mode);
    // slow whenever a low unit is enabled at normal performance
    next_wake_slow = (l[SSMD_B_SV_EN] && !l[SSMD_B_SV_FP]) ||
                     (l[SSMD_B_MON_EN] && !l[SSMD_B_MON_FP]);
    next_affected = low_fast && ((h[SSMD_B_SV_EN] && !h[SSMD_B_SV_FP] &&
                    (!h[SSMD_B_SV_KEEP] || h[SSMD_B_AUTO])) ||
                    (h[SSMD_B_MON_EN] && !h[SSMD_B_MON_FP] && h[SSMD_B_AUTO]));
  end

  // events: early deep entry, exposed config in deep sleep, settle done
  always_comb begin
    ev[0] = deep_entry_early;
    ev[1] = mode_chg && (next_mode == SSMD_DEEP) && next_affected;
    ev[2] = (low_cnt == 18'h1) || (high_cnt == 18'h1);
    next_irq_stat = irq_stat;
    if (wr_fire && aw_addr == SSMD_ADDR_IRQ_CLR) begin
      next_irq_stat = irq_stat & ~w_data[2:0];
    end
    // set beats clear in the same cycle
    next_irq_stat = next_irq_stat | ev;
  end

  always_comb begin
    next_rvalid = rvalid;
    next_rdata = rdata;
    next_rresp = rresp;
    if (s_axi_arvalid_i && s_axi_arready_o) begin
      next_rvalid = 1'b1;
      next_rresp = SSMD_RESP_OKAY;
      next_rdata = 32'h0;
      unique case (s_axi_araddr_i)
        SSMD_ADDR_LOW_CTL: next_rdata = {26'h0, low_ctl};
        SSMD_ADDR_HIGH_CTL: next_rdata = {26'h0, high_ctl};
        SSMD_ADDR_MODE: next_rdata = {29'h0, mode};
        SSMD_ADDR_STATE: next_rdata = {20'h0, affected_config_o, wake_slow_o,
                                       high_side_settling_flag_o, low_side_settling_flag_o,
                                       high_mon_state_o, high_sv_state_o,
                                       low_mon_state_o, low_sv_state_o};
        SSMD_ADDR_IRQ_STAT: next_rdata = {29'h0, irq_stat};
        SSMD_ADDR_IRQ_EN: next_rdata = {29'h0, irq_en};
        SSMD_ADDR_IRQ_CLR: ;
        default: next_rresp = SSMD_RESP_SLVERR;
      endcase
    end else if (rvalid && s_axi_rready_i) begin
      next_rvalid = 1'b0;
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      aw_got <= 1'b0;
      aw_addr <= 8'h00;
      w_got <= 1'b0;
      w_data <= 32'h0;
      bvalid <= 1'b0;
      bresp <= SSMD_RESP_OKAY;
      rvalid <= 1'b0;
      rdata <= 32'h0;
      rresp <= SSMD_RESP_OKAY;
      low_ctl <= SSMD_CTL_RESET;
      high_ctl <= SSMD_CTL_RESET;
      low_snap <= SSMD_CTL_RESET;
      high_snap <= SSMD_CTL_RESET;
      mode <= SSMD_ACTIVE;
      low_cnt <= 18'h0;
      high_cnt <= 18'h0;
      irq_stat <= 3'h0;
      irq_en <= 3'h0;
      low_sv_state_o <= SSMD_OFF;
      low_mon_state_o <= SSMD_OFF;
      high_sv_state_o <= SSMD_OFF;
      high_mon_state_o <= SSMD_OFF;
      wake_slow_o <= 1'b0;
      affected_config_o <= 1'b0;
    end else begin
      aw_got <= next_aw_got;
      aw_addr <= next_aw_addr;
      w_got <= next_w_got;
      w_data <= next_w_data;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      rvalid <= next_rvalid;
      rdata <= next_rdata;
      rresp <= next_rresp;
      low_ctl <= next_low_ctl;
      high_ctl <= next_high_ctl;
      low_snap <= next_low_snap;
      high_snap <= next_high_snap;
      mode <= next_mode;
      low_cnt <= next_low_cnt;
      high_cnt <= next_high_cnt;
      irq_stat <= next_irq_stat;
      irq_en <= next_irq_en;
      low_sv_state_o <= next_lsv;
      low_mon_state_o <= next_lmon;
      high_sv_state_o <= next_hsv;
      high_mon_state_o <= next_hmon;
      wake_slow_o <= next_wake_slow;
      affected_config_o <= next_affected;
    end
  end

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);

  dis_off_a: assert property (!low_ctl[SSMD_B_SV_EN] && mode != SSMD_DEEP
    |-> low_sv_state_o == SSMD_OFF)
    else $error("disabled low supervisor not off");
  full_awake_a: assert property (low_ctl[2:0] == 3'h5 && mode == SSMD_ACTIVE && $stable(low_ctl)
    && $stable(mode) |-> low_sv_state_o == SSMD_FULL)
    else $error("low supervisor not full");
  norm_awake_a: assert property (low_ctl[2:0] == 3'h1 && mode == SSMD_LIGHT && $stable(low_ctl)
    && $stable(mode) |-> low_sv_state_o == SSMD_NORMAL)
    else $error("low supervisor not normal");
  deep_keep_a: assert property (mode == SSMD_DEEP && low_snap == 6'h07 && $stable(mode)
    |-> low_sv_state_o == SSMD_FULL)
    else $error("manual deep full lost");
  deep_auto_a: assert property (mode == SSMD_DEEP && low_snap == 6'h23 && $stable(mode)
    |-> low_sv_state_o == SSMD_OFF)
    else $error("auto deep keep not off");
  high_same_a: assert property ($stable(mode) && $stable(low_ctl) && $stable(high_ctl) &&
    $stable(low_snap) && $stable(high_snap) && low_ctl == high_ctl && low_snap == high_snap
    |-> high_sv_state_o == low_sv_state_o)
    else $error("high side decode differs");
  slow_wake_a: assert property ($changed(low_ctl) && mode != SSMD_DEEP &&
    low_ctl[SSMD_B_SV_EN] && !low_ctl[SSMD_B_SV_FP] |=> wake_slow_o)
    else $error("slow wake not selected");
  snap_hold_a: assert property (mode_chg |=> low_snap == $past(low_ctl))
    else $error("snapshot not taken");
  settle_run_a: assert property (low_wr |=> low_side_settling_flag_o [*8])
    else $error("settling flag dropped early");
  early_irq_a: assert property (deep_entry_early |=> irq_stat[0])
    else $error("early deep entry not flagged");
  check_a: assert property (mode != SSMD_DEEP && $stable(low_ctl) && $stable(high_ctl) &&
    $stable(mode) && !wake_slow_o && high_ctl[2:0] == 3'h1 |-> affected_config_o)
    else $error("affected check missed");
  deep_c: cover property (mode_chg && next_mode == SSMD_DEEP);
  early_c: cover property (deep_entry_early);
  aff_c: cover property (affected_config_o && mode == SSMD_DEEP);
  irq_c: cover property (irq_o);
endmodule : ssmd_top

// ===== core/ssmd_pkg.sv
package ssmd_pkg;
  typedef enum logic [1:0] {
    SSMD_OFF = 2'h0,
    SSMD_NORMAL = 2'h1,
    SSMD_FULL = 2'h2
  } ssmd_unit_e;
  typedef enum logic [2:0] {
    SSMD_ACTIVE = 3'h1,
    SSMD_LIGHT = 3'h2,
    SSMD_DEEP = 3'h4
  } ssmd_mode_e;
  localparam logic [7:0] SSMD_ADDR_LOW_CTL = 8'h00;
  localparam logic [7:0] SSMD_ADDR_HIGH_CTL = 8'h04;
  localparam logic [7:0] SSMD_ADDR_MODE = 8'h08;
  localparam logic [7:0] SSMD_ADDR_STATE = 8'h0C;
  localparam logic [7:0] SSMD_ADDR_IRQ_STAT = 8'h10;
  localparam logic [7:0] SSMD_ADDR_IRQ_EN = 8'h14;
  localparam logic [7:0] SSMD_ADDR_IRQ_CLR = 8'h18;
  // control field positions, shared by both sides
  localparam int SSMD_B_SV_EN = 0;
  localparam int SSMD_B_SV_KEEP = 1;
  localparam int SSMD_B_SV_FP = 2;
  localparam int SSMD_B_MON_EN = 3;
  localparam int SSMD_B_MON_FP = 4;
  localparam int SSMD_B_AUTO = 5;
  localparam logic [5:0] SSMD_CTL_RESET = 6'h00;
  // settling delay after a control write, ns
  localparam int SSMD_CLK_NS = 25;
  localparam int SSMD_SETTLE_NS = 150000;
  localparam int SSMD_SETTLE_CYC = (SSMD_SETTLE_NS + SSMD_CLK_NS - 1) / SSMD_CLK_NS;
  localparam int SSMD_WAKE_SLOW_NS = 150000;
  localparam logic [1:0] SSMD_RESP_OKAY = 2'h0;
  localparam logic [1:0] SSMD_RESP_SLVERR = 2'h2;
endpackage : ssmd_pkg

// ===== tb/ssmd_core_model.sv
`timescale 1ns/1ps
module ssmd_core_model (
  // clock and settling flags
  input wire logic core_clk_i,
  input wire logic low_settle_i,
  input wire logic high_settle_i,
  // write channels
  output logic [7:0] awaddr_o,
  output logic awvalid_o,
  input wire logic awready_i,
  output logic [31:0] wdata_o,
  output logic wvalid_o,
  input wire logic wready_i,
  input wire logic bvalid_i,
  output logic bready_o,
  // read channels
  output logic [7:0] araddr_o,
  output logic arvalid_o,
  input wire logic arready_i,
  input wire logic rvalid_i,
  output logic rready_o
);
  initial begin
    {awaddr_o, awvalid_o, wdata_o, wvalid_o, bready_o} = '0;
    {araddr_o, arvalid_o, rready_o} = '0;
  end
  task automatic write(input logic [7:0] a, input logic [31:0] d);
    logic aw_done;
    logic w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    @(posedge core_clk_i);
    awaddr_o <= a;
    awvalid_o <= 1'b1;
    wdata_o <= d;
    wvalid_o <= 1'b1;
    bready_o <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(posedge core_clk_i);
      if (!aw_done && awready_i) begin
        aw_done = 1'b1;
        awvalid_o <= 1'b0;
      end
      if (!w_done && wready_i) begin
        w_done = 1'b1;
        wvalid_o <= 1'b0;
      end
    end
    while (!bvalid_i) @(posedge core_clk_i);
    bready_o <= 1'b0;
  endtask : write
  task automatic read(input logic [7:0] a);
    @(posedge core_clk_i);
    araddr_o <= a;
    arvalid_o <= 1'b1;
    rready_o <= 1'b1;
    // ar counts only at an edge after it was raised
    do begin
      @(posedge core_clk_i);
    end while (!arready_i);
    arvalid_o <= 1'b0;
    do begin
      @(posedge core_clk_i);
    end while (!rvalid_i);
    rready_o <= 1'b0;
  endtask : read
  // flags rise an edge after the write lands, so look late
  task automatic settle();
    repeat (2) @(posedge core_clk_i);
    while (low_settle_i || high_settle_i) @(posedge core_clk_i);
  endtask : settle
endmodule : ssmd_core_model

// ===== tb/test_supply_supervisor_mode_decoder.sv
`timescale 1ns/1ps
module test_supply_supervisor_mode_decoder;
  import ssmd_pkg::*;
  logic core_clk_i, rst_i, awvalid, awready, wvalid, wready, bvalid, bready, irq;
  logic arvalid, arready, rvalid, rready, lflag, hflag;
  logic [7:0] awaddr, araddr, seed;
  logic [31:0] wdata, rdata;
  logic [1:0] bresp, rresp;
  logic [5:0] l, h;
  logic [1:0] wr_q[$];
  logic [34:0] rd_q[$];
  logic [34:0] e;
  int n_errors = 0;
  int checks_done = 0;
  ssmd_top #(.SETTLE_CYC(20)) dut (.core_clk_i(core_clk_i), .rst_i(rst_i),
    .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
    .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wvalid),
    .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
    .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
    .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
    .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .low_sv_state_o(),
    .low_mon_state_o(), .high_sv_state_o(), .high_mon_state_o(), .wake_slow_o(),
    .affected_config_o(), .low_side_settling_flag_o(lflag),
    .high_side_settling_flag_o(hflag), .irq_o(irq));
  ssmd_core_model core (.core_clk_i(core_clk_i), .low_settle_i(lflag), .high_settle_i(hflag),
    .awaddr_o(awaddr), .awvalid_o(awvalid), .awready_i(awready), .wdata_o(wdata),
    .wvalid_o(wvalid), .wready_i(wready), .bvalid_i(bvalid), .bready_o(bready),
    .araddr_o(araddr), .arvalid_o(arvalid), .arready_i(arready), .rvalid_i(rvalid),
    .rready_o(rready));
  function automatic logic [7:0] lfsr(input logic [7:0] x);
    return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
  endfunction : lfsr
  function automatic ssmd_unit_e unit(input logic en, keep, fp, auto_c, deep);
    if (!en) return SSMD_OFF;
    if (!deep) return fp ? SSMD_FULL : SSMD_NORMAL;
    if (!keep) return SSMD_OFF;
    if (auto_c) return fp ? SSMD_NORMAL : SSMD_OFF;
    return fp ? SSMD_FULL : SSMD_NORMAL;
  endfunction : unit
  function automatic logic [31:0] word(input logic [5:0] lo, hi, input logic deep);
    logic slow;
    logic aff;
    slow = (lo[0] && !lo[2]) || (lo[3] && !lo[4]);
    aff = (!(lo[0] && !lo[2]) || !(lo[3] && !lo[4])) &&
      ((hi[0] && !hi[2] && (!hi[1] || hi[5])) || (hi[3] && !hi[4] && hi[5]));
    return {20'h0, aff, slow, 2'b00, unit(hi[3], 1'b1, hi[4], hi[5], deep),
      unit(hi[0], hi[1], hi[2], hi[5], deep), unit(lo[3], 1'b1, lo[4], lo[5], deep),
      unit(lo[0], lo[1], lo[2], lo[5], deep)};
  endfunction : word
  task automatic cmp_word(input logic [31:0] g, x);
    checks_done++;
    if (g !== x) begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, g, x);
    end
  endtask : cmp_word
  task automatic cmp_resp(input logic [1:0] g, x);
    cmp_word({30'h0, g}, {30'h0, x});
  endtask : cmp_resp
  task automatic cmp_level(input logic x);
    repeat (2) @(posedge core_clk_i);
    cmp_word({31'h0, irq}, {31'h0, x});
  endtask : cmp_level
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    wr_q.push_back(r);
    core.write(a, d);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic c, input logic [1:0] r);
    rd_q.push_back({c, r, d});
    core.read(a);
  endtask : rd
  task automatic finish_test();
    $display("errors %0d checks %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : finish_test
  always @(posedge core_clk_i) begin
    if (bvalid && bready) cmp_resp(bresp, wr_q.pop_front());
    if (rvalid && rready) begin
      e = rd_q.pop_front();
      cmp_resp(rresp, e[33:32]);
      if (e[34]) cmp_word(rdata, e[31:0]);
    end
  end
  initial begin
    core_clk_i = 1'b0;
    forever #12.5 core_clk_i = ~core_clk_i;
  end
  initial begin
    repeat (20000) @(posedge core_clk_i);
    n_errors++;
    finish_test();
  end
  initial begin
    rst_i = 1'b1;
    seed = 8'h33;
    repeat (3) @(posedge core_clk_i);
    rst_i <= 1'b0;
    rd(SSMD_ADDR_STATE, 32'h0, 1'b1, SSMD_RESP_OKAY);
    rd(8'h1C, 32'h0, 1'b0, SSMD_RESP_SLVERR);
    wr(SSMD_ADDR_MODE, 32'h3, SSMD_RESP_SLVERR);
    for (int n = 0; n < 24; n++) begin
      seed = lfsr(seed);
      l = seed[5:0];
      seed = lfsr(seed);
      h = seed[5:0];
      wr(SSMD_ADDR_LOW_CTL, {26'h0, l}, SSMD_RESP_OKAY);
      wr(SSMD_ADDR_HIGH_CTL, {26'h0, h}, SSMD_RESP_OKAY);
      core.settle();
      wr(SSMD_ADDR_MODE, seed[6] ? 32'(SSMD_LIGHT) : 32'(SSMD_ACTIVE), SSMD_RESP_OKAY);
      rd(SSMD_ADDR_STATE, word(l, h, 1'b0), 1'b1, SSMD_RESP_OKAY);
      wr(SSMD_ADDR_MODE, 32'(SSMD_DEEP), SSMD_RESP_OKAY);
      rd(SSMD_ADDR_STATE, word(l, h, 1'b1), 1'b1, SSMD_RESP_OKAY);
      wr(SSMD_ADDR_LOW_CTL, {26'h0, ~l}, SSMD_RESP_OKAY);
      // low settling still runs after the write
      rd(SSMD_ADDR_STATE, word(l, h, 1'b1) | 32'h100, 1'b1, SSMD_RESP_OKAY);
      wr(SSMD_ADDR_MODE, 32'(SSMD_ACTIVE), SSMD_RESP_OKAY);
    end
    core.settle();
    wr(SSMD_ADDR_IRQ_CLR, 32'h7, SSMD_RESP_OKAY);
    wr(SSMD_ADDR_IRQ_EN, 32'h1, SSMD_RESP_OKAY);
    cmp_level(1'b0);
    // deliberate early deep entry, the core breaks the settling wait here
    wr(SSMD_ADDR_LOW_CTL, 32'h9, SSMD_RESP_OKAY);
    wr(SSMD_ADDR_MODE, 32'(SSMD_DEEP), SSMD_RESP_OKAY);
    rd(SSMD_ADDR_IRQ_STAT, 32'h1, 1'b1, SSMD_RESP_OKAY);
    cmp_level(1'b1);
    core.settle();
    wr(SSMD_ADDR_IRQ_EN, 32'h0, SSMD_RESP_OKAY);
    cmp_level(1'b0);
    wr(SSMD_ADDR_IRQ_EN, 32'h7, SSMD_RESP_OKAY);
    cmp_level(1'b1);
    wr(SSMD_ADDR_IRQ_CLR, 32'h7, SSMD_RESP_OKAY);
    cmp_level(1'b0);
    wr(SSMD_ADDR_MODE, 32'(SSMD_ACTIVE), SSMD_RESP_OKAY);
    // fast low side, high units kept on under manual control
    wr(SSMD_ADDR_LOW_CTL, 32'h5, SSMD_RESP_OKAY);
    wr(SSMD_ADDR_HIGH_CTL, 32'hB, SSMD_RESP_OKAY);
    core.settle();
    wr(SSMD_ADDR_MODE, 32'(SSMD_DEEP), SSMD_RESP_OKAY);
    rd(SSMD_ADDR_STATE, word(6'h05, 6'h0B, 1'b1), 1'b1, SSMD_RESP_OKAY);
    finish_test();
  end
endmodule : test_supply_supervisor_mode_decoder
